// *** src/clk_out_pkg.sv ***
package clk_out_pkg;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_N1 = 6'h05;
  localparam logic [5:0] IDX_MODE = 6'h0b;
  localparam logic [5:0] IDX_LOOP = 6'h0c;
  localparam logic [5:0] IDX_FB = 6'h0f;
  localparam logic [5:0] IDX_N2 = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h11;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int MODE_AUX_DIFF = 2;
  localparam int MODE_AUX_LOAD = 3;
  localparam int LOOP_RSVD = 0;
  localparam int LOOP_HOLD = 1;
  localparam int LOOP_FREEZE = 2;
  localparam int LOOP_BYPASS = 3;
  localparam int FB_ALT = 0;
  localparam int FB_PIN_EN = 3;

  // ---------------------------------------------------------------
  // Values after reset, and the fixed reference and feedback divider moduli.
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] LOOP_RST = 4'h0;
  localparam logic [3:0] FB_RST = 4'h0;
  localparam logic [3:0] N1_RST = 4'h1;
  localparam logic [8:0] N2_RST = 9'h002;
  localparam logic [8:0] REF_DIV_DEF = 9'h004;
  localparam logic [8:0] FB_DIV_DEF = 9'h008;

  // ---------------------------------------------------------------
  // Modes and answers.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCALE_1 = 2'b00,
    SCALE_2 = 2'b01,
    SCALE_4 = 2'b10,
    SCALE_AUX = 2'b11
  } scale_mode_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic [8:0] n1_modulus(input logic [3:0] code);
    logic [8:0] m;
    m = 9'h004;
    if (code[3]) begin
      case (code[1:0])
        2'b00: m = 9'h00c;
        2'b01: m = 9'h010;
        2'b10: m = 9'h010;
        default: m = 9'h014;
      endcase
    end else begin
      case (code[2:0])
        3'b000: m = 9'h003;
        3'b001: m = 9'h004;
        3'b010: m = 9'h004;
        3'b011: m = 9'h005;
        3'b100: m = 9'h006;
        3'b101: m = 9'h008;
        3'b110: m = 9'h008;
        default: m = 9'h00a;
      endcase
    end
    return m;
  endfunction

endpackage

// *** src/tick_divider.sv ***
`timescale 1ns/1ps
module tick_divider
  import clk_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [8:0] modulus_i,
  output logic out_o
);

  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [8:0] mod_eff;
  logic [8:0] half;

  // Moduli below two would stall the output, so they act as two.
  always_comb begin
    mod_eff = (modulus_i < 9'h002) ? 9'h002 : modulus_i;
    half = 9'((mod_eff + 9'h001) >> 1);
    cnt_nxt = cnt_r;
    if (clear_i) begin
      cnt_nxt = 9'h000;
    end else if (tick_i) begin
      cnt_nxt = (cnt_r >= mod_eff - 9'h001) ? 9'h000 : 9'(cnt_r + 9'h001);
    end
    out_nxt = (cnt_nxt < half);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 9'h000;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign out_o = out_r;

endmodule

// *** src/axil_regs.sv ***
`timescale 1ns/1ps
module axil_regs
  import clk_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output logic [5:0] wr_idx_o,
  output logic [3:0] wr_data_o,
  input wire logic wr_ok_i,
  output logic [5:0] rd_idx_o,
  input wire logic [3:0] rd_data_i,
  input wire logic rd_ok_i
);

  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [5:0] aw_idx_r, aw_idx_nxt;
  logic [3:0] wd_r, wd_nxt;
  logic ws_r, ws_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    aw_idx_nxt = aw_idx_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    do_wr = aw_held_r && w_held_r && !bvalid_r;
    if (awvalid_i && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_idx_nxt = awaddr_i[7:2];
    end
    if (wvalid_i && !w_held_r) begin
      w_held_nxt = 1'b1;
      wd_nxt = wdata_i[3:0];
      ws_nxt = wstrb_i[0];
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready_i) begin
      rvalid_nxt = 1'b0;
    end else if (arvalid_i && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = {28'h0000000, rd_ok_i ? rd_data_i : 4'h0};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 6'h00;
      wd_r <= 4'h0;
      ws_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_idx_r <= aw_idx_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Readies are registered levels, so a held word waits until its partner arrives.
  assign awready_o = !aw_held_r;
  assign wready_o = !w_held_r;
  assign arready_o = !rvalid_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rresp_o = rresp_r;
  assign rdata_o = rdata_r;
  assign wr_en_o = do_wr && ws_r;
  assign wr_idx_o = aw_idx_r;
  assign wr_data_o = wd_r;
  assign rd_idx_o = araddr_i[7:2];

endmodule

// *** src/clock_output_mode_control.sv ***
`timescale 1ns/1ps
// Contract
// - Scale code 00, 01, 10 divides the differential clock by 1, 2, 4.
// - In scaled modes the first divider drives load, load clocks second divider.
// - Scale code 11 is aux mode: bit 2 sets differential, bit 3 sets load.
// - Outside aux mode, aux load bit forces load to source rate over two.
// - Loop hold floats detector, resets detector and reference, feedback, second counters.
// - Freeze holds positive output high, negative low; all else keeps running.
// - After freeze clears, differential toggling resumes on a load rising edge.
// - Reference bypass feeds the reference into the post-scaler instead of VCO.
// - Alternate feedback puts first and second dividers in the feedback path.
// - Pin enable makes address bit 3 a level reset of the detector.
// - First divider code maps to 3,4,4,5,6,8,8,10 or 12,16,16,20; resets to four.
// - The second divider is fed by the first divider except in aux mode or when the aux load bit is set.
module clock_output_mode_control
  import clk_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ref_clk_i,
  input wire logic address_bit3_pin_i,
  output logic diff_p_o,
  output logic diff_n_o,
  output logic load_clock_pin_o,
  output logic second_load_o,
  output logic pd_hiz_o,
  output logic pd_reset_o,
  output logic pd_ref_o,
  output logic pd_fb_o
);

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  logic [3:0] mode_r, mode_nxt;
  logic [3:0] loop_r, loop_nxt;
  logic [3:0] fb_r, fb_nxt;
  logic [3:0] n1_r, n1_nxt;
  logic [8:0] n2_r, n2_nxt;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [3:0] wr_data;
  logic wr_ok;
  logic [5:0] rd_idx;
  logic [3:0] rd_data;
  logic rd_ok;
  logic [3:0] status;

  scale_mode_t scale_mode;
  logic aux_drive_mode;
  logic aux_diff_level_bit;
  logic aux_load_level_bit;
  logic loop_hold_reset;
  logic diff_output_freeze;
  logic ref_bypass_select;
  logic alt_feedback_select;
  logic detector_reset_pin_enable;

  axil_regs u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .wr_ok_i(wr_ok),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  always_comb begin
    mode_nxt = mode_r;
    loop_nxt = loop_r;
    fb_nxt = fb_r;
    n1_nxt = n1_r;
    n2_nxt = n2_r;
    wr_ok = (wr_idx == IDX_N1) || (wr_idx == IDX_MODE) || (wr_idx == IDX_LOOP) ||
            (wr_idx == IDX_FB) || (wr_idx == IDX_N2);
    if (wr_en) begin
      case (wr_idx)
        IDX_N1: n1_nxt = wr_data;
        IDX_MODE: mode_nxt = wr_data;
        IDX_LOOP: loop_nxt = {wr_data[3:1], 1'b0};
        IDX_FB: fb_nxt = {wr_data[3], 2'b00, wr_data[0]};
        IDX_N2: n2_nxt = {n2_r[8:4], wr_data};
        default: n2_nxt = n2_r;
      endcase
    end
  end

  // Only the low nibble of the second modulus is writable; the top bits keep their reset value.
  always_comb begin
    rd_ok = 1'b1;
    case (rd_idx)
      IDX_N1: rd_data = n1_r;
      IDX_MODE: rd_data = mode_r;
      IDX_LOOP: rd_data = loop_r;
      IDX_FB: rd_data = fb_r;
      IDX_N2: rd_data = n2_r[3:0];
      IDX_STAT: rd_data = status;
      default: begin
        rd_data = 4'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= MODE_RST;
      loop_r <= LOOP_RST;
      fb_r <= FB_RST;
      n1_r <= N1_RST;
      n2_r <= N2_RST;
    end else begin
      mode_r <= mode_nxt;
      loop_r <= loop_nxt;
      fb_r <= fb_nxt;
      n1_r <= n1_nxt;
      n2_r <= n2_nxt;
    end
  end

  assign scale_mode = scale_mode_t'(mode_r[1:0]);
  assign aux_drive_mode = (scale_mode == SCALE_AUX);
  assign aux_diff_level_bit = mode_r[MODE_AUX_DIFF];
  assign aux_load_level_bit = mode_r[MODE_AUX_LOAD];
  assign loop_hold_reset = loop_r[LOOP_HOLD];
  assign diff_output_freeze = loop_r[LOOP_FREEZE];
  assign ref_bypass_select = loop_r[LOOP_BYPASS];
  assign alt_feedback_select = fb_r[FB_ALT];
  assign detector_reset_pin_enable = fb_r[FB_PIN_EN];

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  logic [2:0] ref_sync_r, ref_sync_nxt;
  logic [2:0] ad3_sync_r, ad3_sync_nxt;
  logic ref_lvl_r, ref_lvl_nxt;
  logic ad3_lvl_r, ad3_lvl_nxt;
  logic ref_rise;

  // A level is taken only when the second and third stages agree.
  always_comb begin
    ref_sync_nxt = {ref_sync_r[1:0], ref_clk_i};
    ad3_sync_nxt = {ad3_sync_r[1:0], address_bit3_pin_i};
    ref_lvl_nxt = (ref_sync_r[1] == ref_sync_r[2]) ? ref_sync_r[2] : ref_lvl_r;
    ad3_lvl_nxt = (ad3_sync_r[1] == ad3_sync_r[2]) ? ad3_sync_r[2] : ad3_lvl_r;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sync_r <= 3'h0;
      ad3_sync_r <= 3'h0;
      ref_lvl_r <= 1'b0;
      ad3_lvl_r <= 1'b0;
    end else begin
      ref_sync_r <= ref_sync_nxt;
      ad3_sync_r <= ad3_sync_nxt;
      ref_lvl_r <= ref_lvl_nxt;
      ad3_lvl_r <= ad3_lvl_nxt;
    end
  end

  assign ref_rise = ref_lvl_nxt && !ref_lvl_r;

  // ---------------------------------------------------------------
  // Post-scaler and differential clock.
  // ---------------------------------------------------------------
  logic src_tick;
  logic scaled_tick;
  logic [1:0] ps_cnt_r, ps_cnt_nxt;
  logic diff_int_r, diff_int_nxt;
  logic diff_rise;
  logic load_rise;
  logic frozen_r, frozen_nxt;
  logic diff_p_r, diff_p_nxt;
  logic diff_n_r, diff_n_nxt;

  // The VCO is modelled as one tick per system clock.
  always_comb begin
    src_tick = ref_bypass_select ? ref_rise : 1'b1;
    ps_cnt_nxt = src_tick ? 2'(ps_cnt_r + 2'b01) : ps_cnt_r;
    case (scale_mode)
      SCALE_1: scaled_tick = src_tick;
      SCALE_2: scaled_tick = src_tick && (ps_cnt_r[0] == 1'b0);
      SCALE_4: scaled_tick = src_tick && (ps_cnt_r == 2'b00);
      default: scaled_tick = 1'b0;
    endcase
    diff_int_nxt = scaled_tick ? !diff_int_r : diff_int_r;
    diff_rise = scaled_tick && !diff_int_r;
  end

  // Freeze only masks the pins; the internal clock and dividers keep running.
  always_comb begin
    frozen_nxt = frozen_r;
    if (diff_output_freeze) begin
      frozen_nxt = 1'b1;
    end else if (load_rise) begin
      frozen_nxt = 1'b0;
    end
    if (frozen_nxt) begin
      diff_p_nxt = 1'b1;
      diff_n_nxt = 1'b0;
    end else if (aux_drive_mode) begin
      diff_p_nxt = aux_diff_level_bit;
      diff_n_nxt = !aux_diff_level_bit;
    end else begin
      diff_p_nxt = diff_int_nxt;
      diff_n_nxt = !diff_int_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_cnt_r <= 2'b00;
      diff_int_r <= 1'b0;
      frozen_r <= 1'b0;
      diff_p_r <= 1'b0;
      diff_n_r <= 1'b1;
    end else begin
      ps_cnt_r <= ps_cnt_nxt;
      diff_int_r <= diff_int_nxt;
      frozen_r <= frozen_nxt;
      diff_p_r <= diff_p_nxt;
      diff_n_r <= diff_n_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Load dividers.
  // ---------------------------------------------------------------
  logic n1_out;
  logic n2_out;
  logic load_int_r, load_int_nxt;
  logic load_d_r;

  tick_divider u_first_load_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .tick_i(diff_rise),
    .modulus_i(n1_modulus(n1_r)),
    .out_o(n1_out)
  );

  always_comb begin
    if (aux_drive_mode) begin
      load_int_nxt = aux_load_level_bit;
    end else if (aux_load_level_bit) begin
      load_int_nxt = src_tick ? !load_int_r : load_int_r;
    end else begin
      load_int_nxt = n1_out;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_int_r <= 1'b0;
      load_d_r <= 1'b0;
    end else begin
      load_int_r <= load_int_nxt;
      load_d_r <= load_int_r;
    end
  end

  assign load_rise = load_int_r && !load_d_r;

  // The second divider counts load edges, so in aux mode it advances only when the static load bit rises.
  tick_divider u_second_load_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(loop_hold_reset),
    .tick_i(load_rise),
    .modulus_i(n2_r),
    .out_o(n2_out)
  );

  // ---------------------------------------------------------------
  // Reference and feedback counters, phase detector.
  // ---------------------------------------------------------------
  logic [8:0] ref_cnt_r, ref_cnt_nxt;
  logic [8:0] fbk_cnt_r, fbk_cnt_nxt;
  logic ref_div_r, ref_div_nxt;
  logic fbk_div_r, fbk_div_nxt;
  logic pd_fb_nxt;
  logic pd_hiz_r, pd_reset_r, pd_ref_r, pd_fb_r;

  always_comb begin
    ref_cnt_nxt = ref_cnt_r;
    ref_div_nxt = ref_div_r;
    fbk_cnt_nxt = fbk_cnt_r;
    fbk_div_nxt = fbk_div_r;
    if (loop_hold_reset) begin
      ref_cnt_nxt = 9'h000;
      ref_div_nxt = 1'b0;
      fbk_cnt_nxt = 9'h000;
      fbk_div_nxt = 1'b0;
    end else begin
      if (ref_rise) begin
        ref_cnt_nxt = (ref_cnt_r == REF_DIV_DEF - 9'h001) ? 9'h000 : 9'(ref_cnt_r + 9'h001);
        ref_div_nxt = (ref_cnt_nxt == 9'h000) ? !ref_div_r : ref_div_r;
      end
      fbk_cnt_nxt = (fbk_cnt_r == FB_DIV_DEF - 9'h001) ? 9'h000 : 9'(fbk_cnt_r + 9'h001);
      fbk_div_nxt = (fbk_cnt_nxt == 9'h000) ? !fbk_div_r : fbk_div_r;
    end
    pd_fb_nxt = alt_feedback_select ? n2_out : fbk_div_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_r <= 9'h000;
      fbk_cnt_r <= 9'h000;
      ref_div_r <= 1'b0;
      fbk_div_r <= 1'b0;
      pd_hiz_r <= 1'b0;
      pd_reset_r <= 1'b0;
      pd_ref_r <= 1'b0;
      pd_fb_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      fbk_cnt_r <= fbk_cnt_nxt;
      ref_div_r <= ref_div_nxt;
      fbk_div_r <= fbk_div_nxt;
      pd_hiz_r <= loop_hold_reset;
      pd_reset_r <= loop_hold_reset || (detector_reset_pin_enable && ad3_lvl_r);
      pd_ref_r <= ref_div_nxt;
      pd_fb_r <= pd_fb_nxt;
    end
  end

  assign status = {frozen_r, n2_out, load_int_r, diff_int_r};
  assign diff_p_o = diff_p_r;
  assign diff_n_o = diff_n_r;
  assign load_clock_pin_o = load_int_r;
  assign second_load_o = n2_out;
  assign pd_hiz_o = pd_hiz_r;
  assign pd_reset_o = pd_reset_r;
  assign pd_ref_o = pd_ref_r;
  assign pd_fb_o = pd_fb_r;

endmodule

// *** testbench/clock_output_mode_control_monitor.sv ***
`timescale 1ns/1ps
module clock_output_mode_control_monitor
  import clk_out_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic [7:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  input logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  input logic s_axi_wready_o,
  input logic s_axi_bvalid_o,
  input logic s_axi_arvalid_i,
  input logic s_axi_arready_o,
  input logic s_axi_rvalid_o,
  input logic address_bit3_pin_i,
  input logic diff_p_o,
  input logic diff_n_o,
  input logic load_clock_pin_o,
  input logic second_load_o,
  input logic pd_hiz_o,
  input logic pd_reset_o,
  input logic pd_fb_o
);
  // ----------------------------------------
  // Shadow of the control nibbles.
  // ----------------------------------------
  // Checks other than the bus and complement ones wait until the shadow has been quiet, so register latency never matters.
  logic [3:0] mode_r, loop_r, fb_r, quiet_r, mode_nxt, loop_nxt, fb_nxt, quiet_nxt;
  logic wr, st;
  assign wr = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign st = (quiet_r == 4'hf);
  always_comb begin
    mode_nxt = mode_r;
    loop_nxt = loop_r;
    fb_nxt = fb_r;
    quiet_nxt = st ? quiet_r : quiet_r + 4'h1;
    if (wr && s_axi_wstrb_i[0]) begin
      quiet_nxt = 4'h0;
      if (s_axi_awaddr_i[7:2] == IDX_MODE) mode_nxt = s_axi_wdata_i[3:0];
      if (s_axi_awaddr_i[7:2] == IDX_LOOP) loop_nxt = s_axi_wdata_i[3:0];
      if (s_axi_awaddr_i[7:2] == IDX_FB) fb_nxt = s_axi_wdata_i[3:0];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= 4'h0;
      loop_r <= 4'h0;
      fb_r <= 4'h0;
      quiet_r <= 4'h0;
    end else begin
      mode_r <= mode_nxt;
      loop_r <= loop_nxt;
      fb_r <= fb_nxt;
      quiet_r <= quiet_nxt;
    end
  end
  // ----------------------------------------
  // Properties.
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_WR: assert property (wr |-> ##[1:2] s_axi_bvalid_o) else $error("write not answered");
  AST_RD: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read not answered");
  AST_CMP: assert property (diff_n_o == !diff_p_o) else $error("pair not complementary");
  AST_S2: assert property (st && mode_r[1:0] == 2'b01 && loop_r[3:2] == 2'b00 && $changed(diff_p_o) |=>
    $stable(diff_p_o) ##1 $changed(diff_p_o)) else $error("divide by two wrong");
  AST_AUX: assert property (st && mode_r[1:0] == 2'b11 && !loop_r[2] |->
    diff_p_o == mode_r[2] && load_clock_pin_o == mode_r[3]) else $error("aux levels wrong");
  AST_FRZ: assert property (st && loop_r[2] |-> diff_p_o && !diff_n_o) else $error("freeze wrong");
  AST_HOLD: assert property (st && loop_r[1] |-> pd_hiz_o && pd_reset_o) else $error("hold wrong");
  AST_FREE: assert property (st && !loop_r[1] && !fb_r[3] |-> !pd_hiz_o && !pd_reset_o)
    else $error("detector held");
  AST_PIN: assert property ((st && fb_r[3] && address_bit3_pin_i) [*8] |-> pd_reset_o)
    else $error("pin reset ignored");
  AST_ALT: assert property (st && fb_r[0] && !loop_r[1] |->
    pd_fb_o == second_load_o || pd_fb_o == $past(second_load_o)) else $error("alt feedback wrong");
  cover property (st && loop_r[2]);
  cover property (st && mode_r[1:0] == 2'b11);
  cover property (st && fb_r[3] && pd_reset_o);
endmodule
bind clock_output_mode_control clock_output_mode_control_monitor i_mon (.*);

// *** testbench/dac_model.sv ***
`timescale 1ns/1ps
module dac_model (
  input wire logic clk_i,
  input wire logic diff_p_i,
  input wire logic diff_n_i,
  input wire logic load_i,
  output int diff_per_o,
  output int ld_diffs_o,
  output int ld_per_o,
  output int ld_age_o,
  output int ld_cnt_o,
  output int bad_o
);
  // ----------------------------------------
  // Edge timing as the converter sees it.
  // ----------------------------------------
  // Sampling on the falling edge keeps the model clear of the launch edge.
  logic p_q = 1'b0;
  logic l_q = 1'b0;
  int dc = 0;
  int lc = 0;
  int nd = 0;
  always @(negedge clk_i) begin
    dc++;
    lc++;
    ld_age_o++;
    if (diff_n_i === diff_p_i) bad_o++;
    if (diff_p_i && !p_q) begin
      diff_per_o = dc;
      dc = 0;
      nd++;
    end
    if (load_i && !l_q) begin
      ld_per_o = lc;
      ld_diffs_o = nd;
      lc = 0;
      nd = 0;
      ld_age_o = 0;
      ld_cnt_o++;
    end
    p_q = diff_p_i;
    l_q = load_i;
  end
endmodule

// *** testbench/clock_output_mode_control_test.sv ***
`timescale 1ns/1ps
module clock_output_mode_control_test import clk_out_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic ref_clk_i, address_bit3_pin_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, diff_p_o, diff_n_o, load_clock_pin_o, second_load_o;
  logic pd_hiz_o, pd_reset_o, pd_ref_o, pd_fb_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] lf = 8'h17;
  logic [5:0] regs[4] = '{IDX_N1, IDX_MODE, IDX_LOOP, IDX_FB};
  int n_errors = 0, n_checks = 0, diff_per, ld_diffs, ld_per, ld_age, ld_cnt, bad, m[64], k, t, rc = 0;
  int tab[16] = '{3, 4, 4, 5, 6, 8, 8, 10, 12, 16, 16, 20, 12, 16, 16, 20};
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rc <= (rc == 2) ? 0 : rc + 1;
    if (rc == 2) ref_clk_i <= !ref_clk_i;
  end
  clock_output_mode_control i_dut (.*);
  dac_model i_dac (.clk_i, .diff_p_i(diff_p_o), .diff_n_i(diff_n_o), .load_i(load_clock_pin_o),
    .diff_per_o(diff_per), .ld_diffs_o(ld_diffs), .ld_per_o(ld_per), .ld_age_o(ld_age), .ld_cnt_o(ld_cnt),
    .bad_o(bad));
  // ----------------------------------------
  // Bus cycles and comparison.
  // ----------------------------------------
  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [7:0] step_lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic wr(input logic [5:0] idx, input logic [3:0] d, input logic [1:0] er, input int n = 20);
    int c;
    c = 0;
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {28'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      c++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1 && c < 50);
    s_axi_bready_i <= 1'b0;
    ck(32'(c < 50), 32'h1);
    ck(32'(s_axi_bresp_o), 32'(er));
    if (er == RESP_OKAY) m[idx] = d;
    wt(n + 1);
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [1:0] er);
    int c;
    c = 0;
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      c++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1 && c < 50);
    s_axi_rready_i <= 1'b0;
    ck(32'(c < 50), 32'h1);
    ck(32'(s_axi_rresp_o), 32'(er));
    ck(s_axi_rdata_o, (er == RESP_OKAY) ? 32'(m[idx]) : 32'h0);
    wt(1);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial begin
    {rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 4'h8;
    {s_axi_arvalid_i, s_axi_rready_i, ref_clk_i, address_bit3_pin_i} <= 4'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= 48'h0;
    s_axi_wstrb_i <= 4'hf;
    foreach (m[i]) m[i] = 0;
    m[IDX_N1] = 1;
    m[IDX_N2] = 2;
    wt(2);
    rst_i <= 1'b0;
    wt(1);
    foreach (regs[i]) rdchk(regs[i], RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      wr(IDX_MODE, 4'(s), RESP_OKAY, 99);
      ck(diff_per, 2 << s);
      ck(ld_diffs, 4);
    end
    wr(IDX_MODE, 4'h0, RESP_OKAY);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_N1, 4'(c), RESP_OKAY, 130);
      ck(ld_diffs, tab[c]);
    end
    wr(IDX_N1, 4'h1, RESP_OKAY);
    wr(IDX_MODE, 4'h8, RESP_OKAY);
    ck(ld_per, 2);
    for (int v = 0; v < 4; v++) begin
      wr(IDX_MODE, {2'(v), 2'b11}, RESP_OKAY);
      ck(32'({diff_p_o, diff_n_o, load_clock_pin_o}), 32'({v[0], !v[0], v[1]}));
    end
    // Reserved bit 0 stays zero in every loop write; freeze is set then cleared.
    wr(IDX_MODE, 4'h0, RESP_OKAY);
    wr(IDX_LOOP, 4'h4, RESP_OKAY);
    k = ld_cnt;
    wt(40);
    ck(32'({diff_p_o, diff_n_o}), 32'h2);
    ck(32'(ld_cnt > k), 32'h1);
    wr(IDX_LOOP, 4'h0, RESP_OKAY, 0);
    t = 0;
    while (diff_p_o !== 1'b0 && t < 60) begin
      @(posedge clk_i);
      t++;
    end
    ck(32'(ld_age <= 4), 32'h1);
    wr(IDX_LOOP, 4'h2, RESP_OKAY);
    k = int'(second_load_o);
    ck(32'({pd_hiz_o, pd_reset_o, pd_ref_o}), 32'h6);
    wt(60);
    ck(32'(second_load_o), 32'(k));
    wr(IDX_LOOP, 4'h8, RESP_OKAY, 80);
    ck(diff_per, 12);
    wr(IDX_LOOP, 4'h0, RESP_OKAY);
    wr(IDX_FB, 4'h8, RESP_OKAY);
    repeat (6) begin
      lf = step_lfsr(lf);
      address_bit3_pin_i <= lf[0];
      wt(12);
      ck(32'(pd_reset_o), 32'(lf[0]));
    end
    address_bit3_pin_i <= 1'b1;
    wr(IDX_FB, 4'h0, RESP_OKAY);
    ck(32'(pd_reset_o), 32'h0);
    wr(IDX_FB, 4'h1, RESP_OKAY, 80);
    wr(6'h20, 4'h5, RESP_SLVERR);
    rdchk(6'h20, RESP_SLVERR);
    foreach (regs[i]) rdchk(regs[i], RESP_OKAY);
    ck(bad, 0);
    end_of_test();
  end
endmodule
